// >>> smdec_pkg.sv
// Shared constants, modes, states and carrier types of the sampler mode controller.
// Assumes a single 250 MHz clock and byte-wide sample memory of two 64 KiB banks.
package smdec_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int PITCH_WR_HZ = 16_000;
  localparam int PITCH_WR_CYC = CLK_HZ / PITCH_WR_HZ;
  localparam int RATE_SLOW_HZ = 8_000;
  localparam int RATE_SLOW_CYC = CLK_HZ / RATE_SLOW_HZ;
  localparam int RATE_STEP_CYC = 96;
  localparam int FRZ_HOLD_MS = 100;
  localparam int FRZ_HOLD_CYC = (CLK_HZ / 1000) * FRZ_HOLD_MS;

  // ********************************************************************
  // Register map and fields
  // ********************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LEN = 8'h08;
  localparam int CTRL_BANK = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam logic [7:0] LEN_DP_INIT = 8'h0F;
  localparam logic [7:0] LEN_REV_INIT = 8'hFF;
  localparam logic [16:0] TX_LAST_PAGE = 17'h00100;
  localparam logic [16:0] TX_LAST_BANK = 17'h10000;
  localparam logic [1:0] KIND_REV = 2'h1;
  localparam logic [1:0] KIND_PIT = 2'h2;

  // ********************************************************************
  // Modes and states
  // ********************************************************************
  typedef enum logic [3:0] {
    MD_BANK = 4'h0, MD_WAVE = 4'h1, MD_DUMP = 4'h2, MD_PDUMP = 4'h3,
    MD_DEL = 4'h4, MD_REV = 4'h5, MD_PIT = 4'h6,
    MD_DEL_FRZ = 4'h8, MD_REV_FRZ = 4'h9, MD_PIT_FRZ = 4'hA,
    MD_LEN_DEL = 4'hC, MD_LEN_REV = 4'hD, MD_LEN_PIT = 4'hE
  } smdec_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_WAVE = 3'h1, ST_EFF = 3'h3, ST_TX = 3'h2, ST_RX = 3'h6
  } smdec_fsm_t;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic re;
    logic we;
    logic [16:0] addr;
    logic [7:0] wdata;
  } smdec_mem_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } smdec_tx_t;

  typedef struct packed {
    logic [2:0] gpin;
    logic [2:0] bpin;
    logic gl;
    logic bl;
    logic gate;
    logic gate_d;
    smdec_mode_t mode;
    logic bank;
    logic [7:0] len_dp;
    logic [7:0] len_rev;
    smdec_fsm_t fsm;
    logic led;
    logic [7:0] page;
    logic [7:0] rc;
    logic pd;
    logic [15:0] per;
    logic [15:0] rcnt;
    logic [15:0] wcnt;
    logic [15:0] wpos;
    logic [15:0] rpos;
    logic [16:0] cnt;
    logic locked;
    logic frz_opt;
    logic frozen;
    logic [24:0] hcnt;
    logic [1:0] ph;
    logic wr_pend;
    logic [7:0] dac;
    smdec_mem_t mem;
    smdec_tx_t tx;
    logic rdy;
    logic hw_pend;
    logic [7:0] haddr_q;
    logic [31:0] hrdata;
  } smdec_st_t;

  localparam smdec_st_t ST_RST = '{
    len_dp: LEN_DP_INIT, len_rev: LEN_REV_INIT, fsm: ST_IDLE, mode: MD_BANK,
    rdy: 1'b1, default: '0};

endpackage

// >>> smdec_ctrl.sv
// Mode controller of a gate-driven sampler: wavetable play, dumps, effects.
// Assumes a byte memory answering a read one cycle after mem.re is seen,
// an external parser that flags incoming dumps and requests, and an ADC
// path that supplies tune_cv, wave_cv and audio_in on this clock.
//
// Summary of operation
// - Wave wait: indicator off, rate keeps updating.
// - Wave gate rise latches page, rate, plays.
// - Page end resamples page and rate, restarts.
// - Dump mode, gate low: receive into bank.
// - Dump request sends selected bank with rate.
// - Sending ignores serial input and gate.
// - Dump mode gate rise starts sending.
// - Page dump moves one 256-byte page.
// - Effects use bank two as buffer.
// - Read, write, advance, wrap at length.
// - Buffer at most whole bank long.
// - Delay starts on gate rise, retriggers.
// - No direct delay to freeze switch.
// - Reverse writes forward, reads backward.
// - Pitch writes at 16 kHz, reads tuned.
// - Freeze stops writing, keeps playing.
// - Short pulse unfrozen; held gate freezes.
// - Gate fall unfreezes; rise refreezes.
// - No direct freeze to plain switch.
// - Length mode: tune sets pages, 1..256.
// - Length mode gate rise captures tune.
// - Delay and pitch length start 16 pages.
// - Reverse length starts at 256 pages.
// - Gate is input OR push button.
`timescale 1ns/1ps

module smdec_ctrl
  import smdec_pkg::*;
#(
  parameter int RATE_SLOW = RATE_SLOW_CYC,
  parameter int RATE_STEP = RATE_STEP_CYC,
  parameter int PITCH_WR = PITCH_WR_CYC,
  parameter int FRZ_HOLD = FRZ_HOLD_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic gate_pin,
  input wire logic button_pin,
  input wire logic [7:0] tune_cv,
  input wire logic [7:0] wave_cv,
  input wire logic [7:0] audio_in,
  input wire logic [7:0] mem_rdata,
  output smdec_mem_t mem,
  input wire logic rx_start,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  input wire logic dump_req,
  output smdec_tx_t tx,
  input wire logic tx_ready,
  output logic led,
  output logic [7:0] dac
);

  // ********************************************************************
  // State and derived terms
  // ********************************************************************
  smdec_st_t s;
  smdec_st_t n;
  logic rise;
  logic rtick;
  logic wtick;
  logic [15:0] rate_now;
  logic [1:0] kind;
  logic eff_sel;
  logic len_sel;
  logic frz_eff;
  logic start;
  logic [7:0] cur_len;
  logic [15:0] last;
  logic [15:0] wpos_inc;
  logic [15:0] rpos_inc;
  logic [15:0] rpos_dec;
  logic [16:0] tx_last;
  logic [16:0] tx_idx;
  logic [31:0] rd_word;

  // Mode classification; the top bits group plain, freeze and length modes.
  assign rise = s.gate & ~s.gate_d;
  assign rtick = (s.rcnt == 16'h0000);
  assign wtick = (s.wcnt == 16'h0000);
  assign rate_now = 16'(RATE_SLOW - RATE_STEP * int'(tune_cv));
  assign kind = s.mode[1:0];
  assign eff_sel = (s.mode[3:2] == 2'b01 || s.mode[3:2] == 2'b10) && kind != 2'b11;
  assign len_sel = (s.mode[3:2] == 2'b11) && kind != 2'b11;
  assign frz_eff = s.locked ? s.frz_opt : s.mode[3];
  assign start = rise && eff_sel && (s.fsm == ST_IDLE || (s.fsm == ST_EFF && !frz_eff));
  assign cur_len = (kind == KIND_REV) ? s.len_rev : s.len_dp;
  // A 16-bit position cannot pass the bank end.
  assign last = {cur_len, 8'hFF};
  assign wpos_inc = (s.wpos >= last) ? 16'h0000 : s.wpos + 16'h0001;
  assign rpos_inc = (s.rpos >= last) ? 16'h0000 : s.rpos + 16'h0001;
  assign rpos_dec = (s.rpos == 16'h0000 || s.rpos > last) ? last : s.rpos - 16'h0001;
  assign tx_last = s.pd ? TX_LAST_PAGE : TX_LAST_BANK;
  assign tx_idx = s.cnt - 17'h00001;

  // Read data is chosen in the address phase so hrdata is a flop output.
  assign rd_word = (haddr[7:0] == REG_CTRL) ? {24'h000000, s.mode, 3'h0, s.bank} :
                   (haddr[7:0] == REG_STATUS) ? {8'h00, 3'h0, s.fsm, s.frozen, s.led,
                                                 s.rpos} :
                   (haddr[7:0] == REG_LEN) ? {16'h0000, s.len_rev, s.len_dp} :
                   32'h00000000;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    n = s;
    n.mem.re = 1'b0;
    n.mem.we = 1'b0;
    n.rdy = 1'b1;
    // Pins pass three flops; a level counts once stages two and three agree.
    n.gpin = {s.gpin[1:0], gate_pin};
    n.bpin = {s.bpin[1:0], button_pin};
    if (s.gpin[2] == s.gpin[1]) begin
      n.gl = s.gpin[1];
    end
    if (s.bpin[2] == s.bpin[1]) begin
      n.bl = s.bpin[1];
    end
    n.gate = s.gl | s.bl;
    n.gate_d = s.gate;

    // Zero-wait slave; a write lands one cycle after its address phase.
    n.hw_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.hw_pend = hwrite;
      n.haddr_q = haddr[7:0];
      n.hrdata = hwrite ? 32'h00000000 : rd_word;
    end
    if (s.hw_pend && s.haddr_q == REG_CTRL) begin
      n.bank = hwdata[CTRL_BANK];
      n.mode = smdec_mode_t'(hwdata[CTRL_MODE_LSB +: 4]);
    end

    // The freeze choice is latched on entry and only a mode outside the delay, reverse and pitch modes frees it.
    if (!eff_sel) begin
      n.locked = 1'b0;
    end else if (!s.locked) begin
      n.locked = 1'b1;
      n.frz_opt = s.mode[3];
    end

    n.rcnt = rtick ? s.per : s.rcnt - 16'h0001;
    n.wcnt = wtick ? 16'(PITCH_WR) : s.wcnt - 16'h0001;
    if (s.ph == 2'h1) begin
      n.ph = 2'h2;
    end
    if (s.ph == 2'h2) begin
      n.ph = 2'h0;
    end

    case (s.fsm)
      ST_IDLE: begin
        n.led = 1'b0;
        n.frozen = 1'b0;
        n.per = rate_now;
        n.page = tune_cv;
        n.rc = tune_cv;
        n.pd = (s.mode == MD_PDUMP);
        n.cnt = 17'h00000;
        n.wpos = 16'h0000;
        if (s.mode == MD_WAVE && rise) begin
          n.fsm = ST_WAVE;
          n.led = 1'b1;
          n.page = wave_cv;
          n.rpos = 16'h0000;
          n.rcnt = 16'h0000;
        end else if (s.mode == MD_DUMP || s.mode == MD_PDUMP) begin
          if (!s.gate && rx_start) begin
            n.fsm = ST_RX;
            n.led = 1'b1;
          end else if (dump_req || rise) begin
            n.fsm = ST_TX;
            n.led = 1'b1;
          end
        end else if (len_sel && (!s.gate || rise)) begin
          // Length is stored as pages minus one, so the knob spans 1 to 256 pages.
          if (kind == KIND_REV) begin
            n.len_rev = tune_cv;
          end else begin
            n.len_dp = tune_cv;
          end
        end
      end
      ST_WAVE: begin
        if (!s.gate || s.mode != MD_WAVE) begin
          n.fsm = ST_IDLE;
          n.led = 1'b0;
        end else if (rtick) begin
          n.mem.re = 1'b1;
          n.mem.addr = {s.bank, s.page, s.rpos[7:0]};
          n.ph = 2'h1;
          n.rpos[7:0] = s.rpos[7:0] + 8'h01;
          if (s.rpos[7:0] == 8'hFF) begin
            n.page = wave_cv;
            n.per = rate_now;
            n.rcnt = rate_now;
          end
        end
        if (s.ph == 2'h2) begin
          n.dac = mem_rdata;
        end
      end
      ST_EFF: begin
        if (!eff_sel) begin
          n.fsm = ST_IDLE;
          n.led = 1'b0;
          n.frozen = 1'b0;
        end else begin
          n.per = rate_now;
          if (frz_eff) begin
            // A pulse shorter than the hold time never freezes the buffer.
            if (!s.gate) begin
              n.hcnt = 25'h0000000;
              n.frozen = 1'b0;
              n.led = 1'b0;
            end else if (s.hcnt == 25'(FRZ_HOLD - 1)) begin
              n.frozen = 1'b1;
              n.led = 1'b1;
            end else begin
              n.hcnt = s.hcnt + 25'h0000001;
            end
          end
          // One port: a read on a tick wins, a pending write takes the next free cycle.
          if (rtick) begin
            n.mem.re = 1'b1;
            n.mem.addr = {1'b1, s.rpos};
            n.ph = 2'h1;
          end else if (s.wr_pend && s.ph == 2'h0 && !s.frozen) begin
            n.mem.we = 1'b1;
            n.mem.addr = {1'b1, s.wpos};
            n.mem.wdata = audio_in;
            n.wr_pend = 1'b0;
            n.wpos = wpos_inc;
          end
          if (s.ph == 2'h2) begin
            n.dac = mem_rdata;
            n.rpos = (kind == KIND_REV) ? rpos_dec : rpos_inc;
            if (kind != KIND_PIT) begin
              n.wr_pend = 1'b1;
            end
          end
          if (kind == KIND_PIT && wtick) begin
            n.wr_pend = 1'b1;
          end
          if (s.frozen) begin
            n.wr_pend = 1'b0;
          end
        end
      end
      ST_TX: begin
        // Gate and serial input are not looked at until the last byte is taken.
        if (s.tx.valid) begin
          if (tx_ready) begin
            n.tx.valid = 1'b0;
            n.cnt = s.cnt + 17'h00001;
            if (s.cnt == tx_last) begin
              n.fsm = ST_IDLE;
              n.led = 1'b0;
            end
          end
        end else if (s.ph == 2'h0) begin
          if (s.cnt == 17'h00000) begin
            n.tx.valid = 1'b1;
            n.tx.data = s.rc;
          end else begin
            n.mem.re = 1'b1;
            n.mem.addr = s.pd ? {s.bank, s.page, tx_idx[7:0]} : {s.bank, tx_idx[15:0]};
            n.ph = 2'h1;
          end
        end
        if (s.ph == 2'h2) begin
          n.tx.valid = 1'b1;
          n.tx.data = mem_rdata;
        end
      end
      ST_RX: begin
        if (rx_valid) begin
          n.mem.we = 1'b1;
          n.mem.addr = s.pd ? {s.bank, s.page, s.wpos[7:0]} : {s.bank, s.wpos};
          n.mem.wdata = rx_byte;
          n.wpos = s.wpos + 16'h0001;
        end
        if (rx_end) begin
          n.fsm = ST_IDLE;
          n.led = 1'b0;
        end
      end
      default: begin
        n.fsm = ST_IDLE;
        n.led = 1'b0;
      end
    endcase

    // A plain effect restarts on every rise: writing from the buffer start, and in reverse reading from the buffer end.
    if (start) begin
      n.fsm = ST_EFF;
      n.wpos = 16'h0000;
      n.rpos = (kind == KIND_REV) ? last : 16'h0000;
      n.rcnt = 16'h0000;
      n.wcnt = 16'h0000;
      n.ph = 2'h0;
      n.wr_pend = 1'b0;
      n.led = !frz_eff;
      n.frozen = 1'b0;
      n.hcnt = 25'h0000000;
    end
  end

  // ********************************************************************
  // Registers and outputs
  // ********************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // Outputs other than hresp, which is tied low, are taken straight from the state flops.
  assign hreadyout = s.rdy;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign mem = s.mem;
  assign tx = s.tx;
  assign led = s.led;
  assign dac = s.dac;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_rise;
    s.gate && !s.gate_d;
  endsequence

  sequence s_wave_go;
    s.fsm == ST_WAVE && s.led;
  endsequence

  property p_wave_wait;
    (s.fsm == ST_IDLE && s.mode == MD_WAVE) |-> !s.led ##1 s.per == $past(rate_now);
  endproperty
  a_wave_wait: assert property (p_wave_wait) else $error("wave wait wrong");

  property p_wave_start;
    (s.fsm == ST_IDLE && s.mode == MD_WAVE) ##0 s_rise |=>
      s_wave_go ##0 s.page == $past(wave_cv);
  endproperty
  a_wave_start: assert property (p_wave_start) else $error("wave start wrong");

  property p_wave_wrap;
    (s.fsm == ST_WAVE && s.mode == MD_WAVE && s.gate && rtick && s.rpos[7:0] == 8'hFF)
      |=> s.rpos[7:0] == 8'h00 && s.page == $past(wave_cv) && s.rcnt == $past(rate_now);
  endproperty
  a_wave_wrap: assert property (p_wave_wrap) else $error("page wrap wrong");

  property p_tx_hold;
    (s.fsm == ST_TX && !(s.tx.valid && tx_ready && s.cnt == tx_last)) |=> s.fsm == ST_TX;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("send ended early");

  property p_dump_gate;
    (s.fsm == ST_IDLE && s.mode == MD_DUMP) ##0 s_rise |=> s.fsm == ST_TX && s.led;
  endproperty
  a_dump_gate: assert property (p_dump_gate) else $error("gate did not send");

  property p_page_len;
    (s.fsm == ST_TX && s.pd) |-> s.cnt <= TX_LAST_PAGE;
  endproperty
  a_page_len: assert property (p_page_len) else $error("page dump too long");

  property p_bank_two;
    (s.mem.we && $past(s.fsm) == ST_EFF) |-> s.mem.addr[16];
  endproperty
  a_bank_two: assert property (p_bank_two) else $error("effect left bank two");

  property p_wrap;
    (s.fsm == ST_EFF && eff_sel && s.wr_pend && s.ph == 2'h0 && !rtick && !s.frozen
     && s.wpos >= last && !rise) |=> s.mem.we && s.wpos == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("buffer wrap wrong");

  property p_frz_still;
    s.frozen |=> !s.mem.we;
  endproperty
  a_frz_still: assert property (p_frz_still) else $error("frozen buffer written");

  property p_unfreeze;
    (s.fsm == ST_EFF && eff_sel && frz_eff && !s.gate) |=> !s.led && !s.frozen;
  endproperty
  a_unfreeze: assert property (p_unfreeze) else $error("freeze not released");

  property p_len_cap;
    (s.fsm == ST_IDLE && len_sel) ##0 s_rise |=> cur_len == $past(tune_cv);
  endproperty
  a_len_cap: assert property (p_len_cap) else $error("length not captured");

endmodule

// >>> smdec_far_model.sv
// Far-side model: the two-bank sample memory and the consumer of the dump byte stream.
// Assumes the controller's memory and send ports on the one bus clock.
`timescale 1ns/1ps

module smdec_far_model
  import smdec_pkg::*;
(
  input wire logic hclk,
  input wire smdec_mem_t mem,
  input wire logic stall,
  output logic [7:0] mem_rdata,
  output logic tx_ready
);
  // ****************
  // Storage
  // ****************
  logic [7:0] store [0:131071];
  logic [1:0] pace;

  // Each byte starts as a pattern of its address, so a read shows where it came from.
  initial begin
    for (int i = 0; i < 131072; i++) begin
      store[i] = 8'(i) ^ 8'(i >> 8);
    end
    mem_rdata = 8'h00;
    tx_ready = 1'b0;
    pace = 2'h0;
  end

  // Read data is good only in the cycle after a read; otherwise it flips, so a late sample shows.
  always @(posedge hclk) begin
    if (mem.we === 1'b1) begin
      store[mem.addr] <= mem.wdata;
    end
    mem_rdata <= (mem.re === 1'b1) ? store[mem.addr] : ~mem_rdata;
    pace <= pace + 2'h1;
    // A stalling consumer takes one byte in four cycles, so the sender must hold its byte.
    tx_ready <= !stall || (pace == 2'h3);
  end
endmodule

// >>> tb_sampler_wave_dump_effect_ctrl.sv
// Self-checking bench of the sampler mode controller: AHB master tasks, pin stimulus,
// queues of memory traffic. Assumes the far-side model and short timing parameters.
`timescale 1ns/1ps

module tb_sampler_wave_dump_effect_ctrl
  import smdec_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } smdec_row_t;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, led, tx_ready;
  logic gate_pin = 1'b0, button_pin = 1'b0, stall = 1'b1;
  logic rx_start = 1'b0, rx_valid = 1'b0, rx_end = 1'b0, dump_req = 1'b0;
  logic [7:0] tune_cv = 8'h00, wave_cv = 8'h00, audio_in = 8'h00, rx_byte = 8'h00;
  logic [7:0] mem_rdata, dac;
  smdec_mem_t mem;
  smdec_tx_t tx;
  logic [16:0] wq[$], rq[$];
  logic [7:0] dq[$];
  int fails = 0;
  int n_compared = 0;
  int n, k;
  smdec_row_t rows [5] = '{
    '{1'b0, 32'h8, 32'h0, {16'h0, LEN_REV_INIT, LEN_DP_INIT}},
    '{1'b1, 32'h0, 32'h11, 32'h0},
    '{1'b0, 32'h0, 32'h0, 32'h11},
    '{1'b1, 32'hC, 32'h5, 32'h0},
    '{1'b0, 32'hC, 32'h0, 32'h0}};

  // ****************
  // Harness
  // ****************
  always #2 hclk = ~hclk;

  // Short counts keep every mode inside a brief run.
  smdec_ctrl #(.RATE_SLOW(40), .RATE_STEP(0), .PITCH_WR(20), .FRZ_HOLD(50)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gate_pin(gate_pin),
    .button_pin(button_pin), .tune_cv(tune_cv), .wave_cv(wave_cv), .audio_in(audio_in),
    .mem_rdata(mem_rdata), .mem(mem), .rx_start(rx_start), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_end(rx_end), .dump_req(dump_req), .tx(tx),
    .tx_ready(tx_ready), .led(led), .dac(dac));

  smdec_far_model u_far (
    .hclk(hclk), .mem(mem), .stall(stall), .mem_rdata(mem_rdata), .tx_ready(tx_ready));

  // Memory traffic is logged so the order of positions can be judged afterwards.
  always @(posedge hclk) begin
    if (mem.we === 1'b1) begin
      wq.push_back(mem.addr);
      dq.push_back(mem.wdata);
    end
    if (mem.re === 1'b1) begin
      rq.push_back(mem.addr);
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic chw(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chb(input string nm, input logic e, input logic g);
    chw(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge hclk);
  endtask

  task automatic gate(input logic v, input int c);
    gate_pin <= v;
    cyc(c);
  endtask

  task automatic note(input string t);
    $display("test %s done, mismatches so far %0d", t, fails);
  endtask

  // One single word transfer; the master waits for hready, however long it takes.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chb("hresp", 1'b0, hresp);
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bounds the whole run at about four times its expected length.
  initial begin
    cyc(100000);
    fails++;
    $display("MISMATCH watchdog expected finish seen timeout");
    test_done();
  end

  // ****************
  // Tests
  // ****************
  initial begin
    cyc(8);
    hresetn <= 1'b1;
    cyc(1);
    foreach (rows[i]) begin
      ahb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chw("reg", rows[i].e, rd);
    end
    note("registers");
    // Wavetable play in bank two; the page follows the wave input at each page end.
    wave_cv <= 8'h3C;
    cyc(10);
    chb("led", 1'b0, led);
    gate(1'b1, 1);
    for (k = 0; k < 50 && mem.re !== 1'b1; k++) @(posedge hclk);
    chb("led", 1'b1, led);
    chw("page", 32'h13C00, {15'h0, mem.addr});
    wave_cv <= 8'h5A;
    for (k = 0; k < 20000 && !(mem.re === 1'b1 && mem.addr[15:8] === 8'h5A); k++)
      @(posedge hclk);
    chw("next", 32'h15A00, {15'h0, mem.addr});
    gate(1'b0, 10);
    chb("led", 1'b0, led);
    note("wave");
    // Page send from the button; requests and gate pulses during it must be ignored.
    ahb(1'b1, 32'h0, 32'h31);
    tune_cv <= 8'h07;
    button_pin <= 1'b1;
    cyc(6);
    button_pin <= 1'b0;
    for (n = 0; n < 257;) begin
      @(posedge hclk);
      dump_req <= (n == 5);
      gate_pin <= (n == 7);
      if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
        chw("tx", {24'h0, (n == 0) ? 8'h07 : 8'(n - 1) ^ 8'h07}, {24'h0, tx.data});
        n++;
      end
    end
    cyc(30);
    chb("led", 1'b0, led);
    chb("txv", 1'b0, tx.valid);
    note("page send");
    // Incoming dump into bank one, written back to back from the bank base.
    ahb(1'b1, 32'h0, 32'h20);
    wq.delete();
    dq.delete();
    rx_start <= 1'b1;
    cyc(1);
    rx_start <= 1'b0;
    cyc(2);
    chb("led", 1'b1, led);
    for (k = 0; k < 3; k++) begin
      rx_valid <= 1'b1;
      rx_byte <= 8'hA0 + 8'(k);
      cyc(1);
    end
    rx_valid <= 1'b0;
    cyc(3);
    rx_end <= 1'b1;
    cyc(1);
    rx_end <= 1'b0;
    cyc(3);
    chb("led", 1'b0, led);
    for (k = 0; k < 3; k++) begin
      chw("rx", {7'h0, 17'(k), 8'hA0 + 8'(k)}, {7'h0, wq[k], dq[k]});
    end
    note("receive");
    // Length is taken on the gate rise, then follows the knob while the gate is low.
    ahb(1'b1, 32'h0, 32'hC0);
    tune_cv <= 8'h03;
    gate(1'b1, 8);
    tune_cv <= 8'h00;
    cyc(4);
    ahb(1'b0, 32'h8, 32'h0);
    chw("len", {16'h0, LEN_REV_INIT, 8'h03}, rd);
    gate(1'b0, 8);
    ahb(1'b0, 32'h8, 32'h0);
    chw("len", {16'h0, LEN_REV_INIT, 8'h00}, rd);
    note("length");
    // Delay over one page: positions wrap after 255, old contents come out first.
    ahb(1'b1, 32'h0, 32'h40);
    audio_in <= 8'h33;
    wq.delete();
    gate(1'b1, 4);
    for (k = 0; k < 20000 && wq.size() < 300; k++) @(posedge hclk);
    for (k = 0; k < 300; k++) begin
      chw("dwr", {15'h0, 1'b1, 8'h00, 8'(k)}, {15'h0, wq[k]});
    end
    chw("dac", 32'h33, {24'h0, dac});
    // The running delay keeps writing while the gate is low, so the log is cleared only
    // once the synchronised rise has restarted the buffer and its first tick is a read.
    gate(1'b0, 8);
    gate(1'b1, 8);
    wq.delete();
    for (k = 0; k < 500 && wq.size() == 0; k++) @(posedge hclk);
    chb("led", 1'b1, led);
    chw("retrig", 32'h10000, {15'h0, wq[0]});
    ahb(1'b1, 32'h0, 32'h80);
    wq.delete();
    cyc(150);
    chb("nofrz", 1'b1, wq.size() > 0);
    gate(1'b0, 4);
    note("delay");
    // Freeze: short pulse runs unfrozen, a held gate freezes, release resumes writing.
    ahb(1'b1, 32'h0, 32'h0);
    ahb(1'b1, 32'h0, 32'h80);
    gate(1'b1, 12);
    chb("led", 1'b0, led);
    gate(1'b0, 40);
    gate(1'b1, 100);
    chb("led", 1'b1, led);
    wq.delete();
    cyc(200);
    chw("frzwr", 32'h0, 32'(wq.size()));
    gate(1'b0, 150);
    chb("led", 1'b0, led);
    chb("unfrz", 1'b1, wq.size() > 0);
    gate(1'b1, 100);
    chb("led", 1'b1, led);
    ahb(1'b1, 32'h0, 32'h40);
    wq.delete();
    cyc(150);
    chb("stayfrz", 1'b1, wq.size() == 0);
    gate(1'b0, 4);
    note("freeze");
    // Reverse reads backward from the buffer end while writing forward.
    ahb(1'b1, 32'h0, 32'h0);
    ahb(1'b1, 32'h0, 32'h50);
    wq.delete();
    rq.delete();
    gate(1'b1, 1);
    for (k = 0; k < 500 && wq.size() < 2; k++) @(posedge hclk);
    chw("rrd0", 32'h1FFFF, {15'h0, rq[0]});
    chw("rrd1", 32'h1FFFE, {15'h0, rq[1]});
    chw("rwr1", 32'h10001, {15'h0, wq[1]});
    gate(1'b0, 4);
    note("reverse");
    // Pitch: writes every 21 cycles, reads every 41 cycles with these parameters.
    ahb(1'b1, 32'h0, 32'h0);
    ahb(1'b1, 32'h0, 32'h60);
    gate(1'b1, 10);
    wq.delete();
    rq.delete();
    cyc(420);
    chb("pitwr", 1'b1, wq.size() >= 19 && wq.size() <= 21);
    chb("pitrd", 1'b1, rq.size() >= 9 && rq.size() <= 11);
    gate(1'b0, 4);
    note("pitch");
    // A second reset in mid-run restores the factory lengths.
    hresetn <= 1'b0;
    cyc(2);
    chb("rled", 1'b0, led);
    chb("rrdy", 1'b1, hreadyout);
    hresetn <= 1'b1;
    cyc(1);
    ahb(1'b0, 32'h8, 32'h0);
    chw("len", {16'h0, LEN_REV_INIT, LEN_DP_INIT}, rd);
    ahb(1'b0, 32'h0, 32'h0);
    chw("ctrl", 32'h0, rd);
    note("reset");
    test_done();
  end
endmodule
